// File: verilog/dram_latency_timing.sv
// latency selection, auto-precharge delay and termination windows of one memory channel
// assumes apb master on the same clock; command strobes are one-cycle synchronous pulses
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`include "lat_timing_defs.svh"
module dram_latency_timing #(
  parameter int BANKS = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wrApReq,
  input wire logic rdApReq,
  input wire logic [$clog2(BANKS)-1:0] apBank,
  input wire logic casWrite,
  input wire logic casRead,
  output logic [BANKS-1:0] prechargeStart,
  output logic termActive,
  output logic [2:0] termValue,
  output logic nonTargetTermEn,
  output logic writeTermOn,
  output logic readTermOn,
  output lat_timing_pkg::lat_type readLatency,
  output lat_timing_pkg::lat_type writeLatency
);
  import lat_timing_pkg::*;

  function automatic lat_type pick(input lat_table_type tbl, input band_type b);
    pick = tbl[b*6 +: 6];
  endfunction : pick

  function automatic lat_type pick2(input lat_table_type tblA, input lat_table_type tblB,
                                    input logic selB, input band_type b);
    pick2 = selB ? pick(tblB, b) : pick(tblA, b);
  endfunction : pick2

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'b00) && (a <= `REG_STATE);
  endfunction : isMapped

  logic [7:0] latencyModeReg_r;
  logic [7:0] ioConfigModeReg_r;
  logic [7:0] terminationModeReg_r;
  logic [7:0] temperatureStatusReg_r;
  logic [7:0] bandConfigReg_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  lat_type readLatency_r;
  lat_type writeLatency_r;
  lat_type writeRecoveryCount_r;
  lat_type readToPrechargeCount_r;
  lat_type wrOnLat_r;
  lat_type wrOffLat_r;
  lat_type rdOnLat_r;
  lat_type rdOffLat_r;
  logic termActive_r;
  logic nonTargetTermEn_r;
  logic [2:0] termValue_r;

  band_type band;
  logic bl32;
  logic readInv;
  logic wlSetB;
  logic termEnabled;
  logic nonTargetEnabled;
  lat_type rlNxt;
  lat_type wlNxt;
  lat_type wrRecNxt;
  lat_type rtpNxt;
  lat_type apCount;
  lat_type winOn [2];
  lat_type winOff [2];
  logic winStart [2];
  logic [1:0] termOn;
  logic [BANKS-1:0] apLoad;
  logic [BANKS-1:0] apBusy;

  // software programs the band that holds the clock it supplies
  assign band = bandConfigReg_r[`BAND_MSB:0];
  assign bl32 = bandConfigReg_r[`BL32_BIT];
  assign readInv = ioConfigModeReg_r[`RD_INV_BIT];
  assign wlSetB = latencyModeReg_r[`WL_SET_BIT];
  assign rlNxt = pick2(`TBL_RL_NODBI, `TBL_RL_DBI, readInv, band);
  assign wlNxt = pick2(`TBL_WL_A, `TBL_WL_B, wlSetB, band);
  assign wrRecNxt = pick(`TBL_NWR, band);
  assign rtpNxt = pick(`TBL_READ_TO_PRECHARGE_COUNT, band) + (bl32 ? `BL32_EXTRA : 6'd0);

  // the enable bit gates the value field and also turns on non-target termination
  assign termEnabled = terminationModeReg_r[`TERM_EN_BIT];
  assign nonTargetEnabled = |{terminationModeReg_r[`TERM_NT_BIT],
                              terminationModeReg_r[`TERM_EN_BIT]};
  // zero in a table marks a band without termination support
  assign winOn[0] = pick2(`TBL_WON_A, `TBL_WON_B, wlSetB, band);
  assign winOff[0] = pick2(`TBL_WOFF_A, `TBL_WOFF_B, wlSetB, band)
                     + (bl32 ? `BL32_EXTRA : 6'd0);
  assign winOn[1] = pick2(`TBL_RON_NODBI, `TBL_RON_DBI, readInv, band);
  // read off values already include the fixed 1.5-cycle postamble
  assign winOff[1] = pick2(`TBL_ROFF_NODBI, `TBL_ROFF_DBI, readInv, band)
                     + (bl32 ? `BL32_EXTRA : 6'd0);
  assign winStart[0] = casWrite && termEnabled && (winOn[0] != 6'd0);
  assign winStart[1] = casRead && nonTargetEnabled && (winOn[1] != 6'd0);

  // apb slave: one access cycle, unmapped words answer with an error
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !isMapped(paddr);
        prdata_r <= 32'h0000_0000;
        if (!pwrite) begin
          unique case (paddr)
            `REG_LATENCY_MODE: prdata_r <= {24'h00_0000, latencyModeReg_r};
            `REG_IO_CONFIG: prdata_r <= {24'h00_0000, ioConfigModeReg_r};
            `REG_TERMINATION: prdata_r <= {24'h00_0000, terminationModeReg_r};
            `REG_TEMPERATURE: prdata_r <= {24'h00_0000, temperatureStatusReg_r};
            `REG_BAND_CONFIG: prdata_r <= {24'h00_0000, bandConfigReg_r};
            `REG_LAT_STATUS: prdata_r <= {2'h0, readToPrechargeCount_r, 2'h0,
                                          writeRecoveryCount_r, 2'h0, writeLatency_r,
                                          2'h0, readLatency_r};
            `REG_TERM_STATUS: prdata_r <= {2'h0, rdOffLat_r, 2'h0, rdOnLat_r, 2'h0,
                                           wrOffLat_r, 2'h0, wrOnLat_r};
            `REG_STATE: prdata_r <= {16'h0000, apBusy, 1'b0, termOn, termValue_r,
                                     nonTargetTermEn_r, termActive_r};
            default: prdata_r <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // mode registers: written at the completing access edge only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latencyModeReg_r <= `LATENCY_MODE_RST;
      ioConfigModeReg_r <= `IO_CONFIG_RST;
      terminationModeReg_r <= `TERMINATION_RST;
      temperatureStatusReg_r <= `TEMPERATURE_RST;
      bandConfigReg_r <= `BAND_CONFIG_RST;
    end else if (ce && psel && penable && pready_r && pwrite && !pslverr_r) begin
      unique case (paddr)
        `REG_LATENCY_MODE: latencyModeReg_r <= pwdata[7:0];
        `REG_IO_CONFIG: ioConfigModeReg_r <= pwdata[7:0];
        `REG_TERMINATION: terminationModeReg_r <= pwdata[7:0];
        `REG_TEMPERATURE: temperatureStatusReg_r <= pwdata[7:0];
        `REG_BAND_CONFIG: bandConfigReg_r <= pwdata[7:0];
        default: latencyModeReg_r <= latencyModeReg_r;
      endcase
    end
  end

  // latency and termination status follow the mode registers one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readLatency_r <= 6'h00;
      writeLatency_r <= 6'h00;
      writeRecoveryCount_r <= 6'h00;
      readToPrechargeCount_r <= 6'h00;
      wrOnLat_r <= 6'h00;
      wrOffLat_r <= 6'h00;
      rdOnLat_r <= 6'h00;
      rdOffLat_r <= 6'h00;
      termActive_r <= 1'b0;
      nonTargetTermEn_r <= 1'b0;
      termValue_r <= 3'h0;
    end else if (ce) begin
      readLatency_r <= rlNxt;
      writeLatency_r <= wlNxt;
      writeRecoveryCount_r <= wrRecNxt;
      readToPrechargeCount_r <= rtpNxt;
      wrOnLat_r <= winOn[0];
      wrOffLat_r <= winOff[0];
      rdOnLat_r <= winOn[1];
      rdOffLat_r <= winOff[1];
      termActive_r <= termEnabled;
      nonTargetTermEn_r <= nonTargetEnabled;
      termValue_r <= termEnabled ? terminationModeReg_r[`TERM_VAL_MSB:0] : 3'h0;
    end
  end

  // write auto-precharge wins when both strobes arrive together; no spacing applied
  assign apCount = wrApReq ? wrRecNxt : rtpNxt;
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      assign apLoad[gb] = (wrApReq || rdApReq) && (apBank == gb);
      ap_delay_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .load(apLoad[gb]),
        .count(apCount),
        .fire(prechargeStart[gb]),
        .busy(apBusy[gb])
      );
    end
  endgenerate

  // termination windows: index 0 is the write window, 1 the non-target read window
  genvar gw;
  generate
    for (gw = 0; gw < 2; gw++) begin : g_win
      win_state_type state_r;
      logic [6:0] cnt_r;
      lat_type onLat_r;
      lat_type offLat_r;
      logic on_r;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          state_r <= WIN_IDLE;
          cnt_r <= 7'h00;
          onLat_r <= 6'h00;
          offLat_r <= 6'h00;
          on_r <= 1'b0;
        end else if (ce) begin
          if (winStart[gw]) begin
            state_r <= WIN_RUN;
            cnt_r <= 7'h00;
            onLat_r <= winOn[gw];
            offLat_r <= winOff[gw];
          end else if (gw == 0 ? !termEnabled : !nonTargetEnabled) begin
            state_r <= WIN_IDLE;
            on_r <= 1'b0;
          end else begin
            unique case (state_r)
              WIN_IDLE: on_r <= 1'b0;
              WIN_RUN: begin
                cnt_r <= cnt_r + 7'h01;
                if (cnt_r + 7'h01 == {1'b0, onLat_r}) begin
                  on_r <= 1'b1;
                end
                if (cnt_r + 7'h01 == {1'b0, offLat_r}) begin
                  on_r <= 1'b0;
                  state_r <= WIN_IDLE;
                end
              end
            endcase
          end
        end
      end
      assign termOn[gw] = on_r;
    end
  endgenerate

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign readLatency = readLatency_r;
  assign writeLatency = writeLatency_r;
  assign termActive = termActive_r;
  assign nonTargetTermEn = nonTargetTermEn_r;
  assign termValue = termValue_r;
  assign writeTermOn = termOn[0];
  assign readTermOn = termOn[1];
  // helper counters for the checks below
  logic [6:0] since0_r;
  ap_kind_type kind0_r;
  logic [6:0] winSince_r [2];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since0_r <= 7'h00;
      kind0_r <= AP_NONE;
    end else if (ce) begin
      if (apLoad[0]) begin
        since0_r <= 7'h00;
        kind0_r <= wrApReq ? AP_WRITE : AP_READ;
      end else if (since0_r != 7'h7f) begin
        since0_r <= since0_r + 7'h01;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      winSince_r[0] <= 7'h00;
      winSince_r[1] <= 7'h00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (winStart[i]) begin
          winSince_r[i] <= 7'h00;
        end else if (winSince_r[i] != 7'h7f) begin
          winSince_r[i] <= winSince_r[i] + 7'h01;
        end
      end
    end
  end

  property p_rd_lat;
    @(posedge clock) disable iff (!rst_n)
    (ce && band == 3'd7) |=> (readLatency == ($past(readInv) ? 6'd40 : 6'd36));
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency column wrong");
  property p_wr_lat;
    @(posedge clock) disable iff (!rst_n)
    (ce && band == 3'd7) |=> (writeLatency == ($past(wlSetB) ? 6'd34 : 6'd18));
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write latency set wrong");
  property p_wr_ap;
    @(posedge clock) disable iff (!rst_n)
    ($rose(prechargeStart[0]) && kind0_r == AP_WRITE) |-> since0_r == {1'b0, wrRecNxt};
  endproperty
  a_wr_ap: assert property (p_wr_ap) else $error("write precharge delay wrong");
  property p_rd_ap;
    @(posedge clock) disable iff (!rst_n)
    ($rose(prechargeStart[0]) && kind0_r == AP_READ && !bl32)
      |-> since0_r == {1'b0, pick(`TBL_READ_TO_PRECHARGE_COUNT, band)};
  endproperty
  a_rd_ap: assert property (p_rd_ap) else $error("read precharge delay wrong");
  property p_rd_ap_bl32;
    @(posedge clock) disable iff (!rst_n)
    ($rose(prechargeStart[0]) && kind0_r == AP_READ && bl32)
      |-> since0_r == {1'b0, pick(`TBL_READ_TO_PRECHARGE_COUNT, band)} + 7'd8;
  endproperty
  a_rd_ap_bl32: assert property (p_rd_ap_bl32) else $error("burst 32 delay wrong");
  property p_term_off;
    @(posedge clock) disable iff (!rst_n)
    (ce && !terminationModeReg_r[`TERM_EN_BIT]) |=> !termActive ##1 !writeTermOn[*2];
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination active while off");
  property p_wr_on;
    @(posedge clock) disable iff (!rst_n)
    ($rose(writeTermOn) && band == 3'd4 && !wlSetB) |-> winSince_r[0] == 7'd4;
  endproperty
  a_wr_on: assert property (p_wr_on) else $error("write termination on late");
  property p_wr_off;
    @(posedge clock) disable iff (!rst_n)
    ($fell(writeTermOn) && band == 3'd7 && !wlSetB)
      |-> winSince_r[0] == (bl32 ? 7'd36 : 7'd28);
  endproperty
  a_wr_off: assert property (p_wr_off) else $error("write termination off wrong");
  property p_nt_off;
    @(posedge clock) disable iff (!rst_n)
    (ce && terminationModeReg_r[`TERM_NT_BIT] == 1'b0 &&
     terminationModeReg_r[`TERM_EN_BIT] == 1'b0) |=> !nonTargetTermEn;
  endproperty
  a_nt_off: assert property (p_nt_off) else $error("non-target enable wrong");
  property p_rd_off;
    @(posedge clock) disable iff (!rst_n)
    ($fell(readTermOn) && band == 3'd7 && !readInv)
      |-> winSince_r[1] == (bl32 ? 7'd58 : 7'd50);
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("read termination off wrong");
  property p_cov_wr_ap;
    @(posedge clock) disable iff (!rst_n)
    $rose(prechargeStart[0]) && kind0_r == AP_WRITE;
  endproperty
  c_wr_ap: cover property (p_cov_wr_ap);
  property p_cov_rd_bl32;
    @(posedge clock) disable iff (!rst_n)
    $rose(prechargeStart[0]) && kind0_r == AP_READ && bl32;
  endproperty
  c_rd_bl32: cover property (p_cov_rd_bl32);
  property p_cov_wterm;
    @(posedge clock) disable iff (!rst_n)
    $fell(writeTermOn);
  endproperty
  c_wterm: cover property (p_cov_wterm);
endmodule : dram_latency_timing

// File: verilog/lat_timing_defs.svh
// constants for the dram latency and timing block: offsets, fields, resets, latency tables
// assumes a 32-bit apb slave with byte addresses and one word per register
//
// What this block does
// - read latency column follows read inversion bit
// - write latency set follows latency mode bit
// - write auto-precharge waits write recovery count
// - read auto-precharge waits read-to-precharge count
// - burst 32 adds eight cycles before read precharge
// - termination active only with the enable bit set
// - write termination on counted from the write command
// - burst 32 adds eight to write off
// - non-target termination enabled by the non-target bit or the enable bit
// - read termination off adds eight for burst 32
`ifndef LAT_TIMING_DEFS_SVH
`define LAT_TIMING_DEFS_SVH

`define REG_LATENCY_MODE 8'h00
`define REG_IO_CONFIG 8'h04
`define REG_TERMINATION 8'h08
`define REG_TEMPERATURE 8'h0c
`define REG_BAND_CONFIG 8'h10
`define REG_LAT_STATUS 8'h14
`define REG_TERM_STATUS 8'h18
`define REG_STATE 8'h1c

`define WL_SET_BIT 6
`define RD_INV_BIT 6
`define TERM_EN_BIT 3
`define TERM_NT_BIT 7
`define TERM_VAL_MSB 2
`define BAND_MSB 2
`define BL32_BIT 4

`define LATENCY_MODE_RST 8'h00
`define IO_CONFIG_RST 8'h00
`define TERMINATION_RST 8'h00
`define TEMPERATURE_RST 8'h00
`define BAND_CONFIG_RST 8'h00

`define BL32_EXTRA 6'd8

// band 7 (1866..2133 mhz) in the top six bits, band 0 (10..266 mhz) at the bottom
`define TBL_RL_NODBI {6'd36, 6'd32, 6'd28, 6'd24, 6'd20, 6'd14, 6'd10, 6'd6}
`define TBL_RL_DBI {6'd40, 6'd36, 6'd32, 6'd28, 6'd22, 6'd16, 6'd12, 6'd6}
`define TBL_WL_A {6'd18, 6'd16, 6'd14, 6'd12, 6'd10, 6'd8, 6'd6, 6'd4}
`define TBL_WL_B {6'd34, 6'd30, 6'd26, 6'd22, 6'd18, 6'd12, 6'd8, 6'd4}
`define TBL_NWR {6'd40, 6'd34, 6'd30, 6'd24, 6'd20, 6'd16, 6'd10, 6'd6}
`define TBL_READ_TO_PRECHARGE_COUNT {6'd16, 6'd14, 6'd12, 6'd10, 6'd8, 6'd8, 6'd8, 6'd8}
`define TBL_WON_A {6'd8, 6'd6, 6'd6, 6'd4, 6'd4, 6'd0, 6'd0, 6'd0}
`define TBL_WON_B {6'd24, 6'd20, 6'd18, 6'd14, 6'd12, 6'd6, 6'd0, 6'd0}
`define TBL_WOFF_A {6'd28, 6'd26, 6'd24, 6'd22, 6'd20, 6'd0, 6'd0, 6'd0}
`define TBL_WOFF_B {6'd44, 6'd40, 6'd36, 6'd32, 6'd28, 6'd22, 6'd0, 6'd0}
`define TBL_RON_NODBI {6'd28, 6'd26, 6'd22, 6'd18, 6'd14, 6'd0, 6'd0, 6'd0}
`define TBL_RON_DBI {6'd32, 6'd30, 6'd26, 6'd22, 6'd16, 6'd0, 6'd0, 6'd0}
`define TBL_ROFF_NODBI {6'd50, 6'd46, 6'd42, 6'd36, 6'd32, 6'd0, 6'd0, 6'd0}
`define TBL_ROFF_DBI {6'd54, 6'd50, 6'd46, 6'd40, 6'd34, 6'd0, 6'd0, 6'd0}

`endif

// File: verilog/lat_timing_pkg.sv
// types shared by the latency and timing block
// assumes the constants header is included alongside
package lat_timing_pkg;
  typedef logic [5:0] lat_type;
  typedef logic [2:0] band_type;
  typedef logic [47:0] lat_table_type;
  typedef enum logic [1:0] {AP_NONE = 2'b00, AP_WRITE = 2'b01, AP_READ = 2'b10} ap_kind_type;
  typedef enum logic {WIN_IDLE = 1'b0, WIN_RUN = 1'b1} win_state_type;
endpackage : lat_timing_pkg

// File: verilog/ap_delay_timer.sv
// per-bank countdown that starts the internal precharge after an auto-precharge burst
// assumes load is a one-cycle request and count is at least one
`timescale 1ns/100ps
module ap_delay_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire lat_timing_pkg::lat_type count,
  output logic fire,
  output logic busy
);
  import lat_timing_pkg::*;

  lat_type cnt_r;
  logic fire_r;
  logic busy_r;

  // fire rises exactly count cycles after the load edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
      fire_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      fire_r <= 1'b0;
      if (load) begin
        cnt_r <= count;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == 6'h01) begin
          fire_r <= 1'b1;
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 6'h01;
        end
      end
    end
  end

  assign fire = fire_r;
  assign busy = busy_r;
endmodule : ap_delay_timer

// File: testbench/ctrl_cmd_model.sv
// memory controller model: issues auto-precharge requests and column commands
// assumes the bench calls issue from its main sequence, on the clock of the block
`timescale 1ns/100ps
module ctrl_cmd_model #(
  parameter int BANKS = 8,
  parameter int MIN_GAP = 4
) (
  input wire logic clock,
  output logic wrApReq,
  output logic rdApReq,
  output logic [$clog2(BANKS)-1:0] apBank,
  output logic casWrite,
  output logic casRead
);
  initial begin
    wrApReq = 1'b0;
    rdApReq = 1'b0;
    apBank = '0;
    casWrite = 1'b0;
    casRead = 1'b0;
  end

  // kind 0 write ap, 1 read ap, 2 write column, 3 read column
  // the bench runs one fixed 100 mhz clock while it programs every band
  task automatic issue(input int kind, input int bank);
    // commands spaced out; ap requests get no extra precharge spacing
    repeat (MIN_GAP - 1) @(posedge clock);
    wrApReq <= (kind == 0);
    rdApReq <= (kind == 1);
    casWrite <= (kind == 2);
    casRead <= (kind == 3);
    apBank <= bank[$clog2(BANKS)-1:0];
    @(posedge clock);
    wrApReq <= 1'b0;
    rdApReq <= 1'b0;
    casWrite <= 1'b0;
    casRead <= 1'b0;
    // bank lines are not held after the request
    apBank <= ~apBank;
  endtask : issue
endmodule : ctrl_cmd_model

// File: testbench/tb_dram_latency_timing.sv
// self-checking bench for the latency and timing block
// assumes the design files and the command model are compiled first
`timescale 1ns/100ps
`include "lat_timing_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_dram_latency_timing;
  import lat_timing_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wrApReq, rdApReq, casWrite, casRead;
  logic termActive, nonTargetTermEn, writeTermOn, readTermOn;
  logic [2:0] apBank, termValue;
  logic [7:0] prechargeStart;
  lat_type readLatency, writeLatency;
  int mismatches = 0;
  int check_count = 0;
  int seed = 98;
  logic [31:0] rd, r, ex;
  logic err, dbi, setB, bl;
  band_type b;
  logic [7:0] tv [0:5] = '{8'h00, 8'h05, 8'h0b, 8'h80, 8'h88, 8'h00};

  always #5 clock = ~clock;

  dram_latency_timing #(.BANKS(8)) dut (.clock(clock), .rst_n(rst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wrApReq(wrApReq), .rdApReq(rdApReq),
    .apBank(apBank), .casWrite(casWrite), .casRead(casRead), .prechargeStart(prechargeStart),
    .termActive(termActive), .termValue(termValue), .nonTargetTermEn(nonTargetTermEn),
    .writeTermOn(writeTermOn), .readTermOn(readTermOn), .readLatency(readLatency),
    .writeLatency(writeLatency));

  ctrl_cmd_model #(.BANKS(8)) cmd (.clock(clock), .wrApReq(wrApReq), .rdApReq(rdApReq),
    .apBank(apBank), .casWrite(casWrite), .casRead(casRead));

  function automatic lat_type pick(input lat_table_type t, input band_type bb);
    return t[int'(bb)*6 +: 6];
  endfunction : pick

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : apb_xfer

  // issue one command, then find the cycles in which the watched output rises and falls
  task automatic measure(input int kind, input int bank, input int on, input int off);
    logic s;
    int onAt;
    int offAt;
    onAt = 0;
    offAt = 0;
    cmd.issue(kind, bank);
    for (int i = 0; i < 80; i++) begin
      #1;
      s = (kind < 2) ? prechargeStart[bank] : (kind == 2) ? writeTermOn : readTermOn;
      if (s === 1'b1 && onAt == 0) onAt = i;
      if (s !== 1'b1 && onAt != 0 && offAt == 0) offAt = i;
      @(posedge clock);
    end
    `CHK(onAt, on)
    if (on != 0) `CHK(offAt, off)
  endtask : measure

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK(readLatency, 6'd6)
    `CHK(writeLatency, 6'd4)
    apb_xfer(1'b1, `REG_BAND_CONFIG, 32'h0000_0007);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(readLatency, 6'd6)
    @(posedge clock);
    ce <= 1'b1;
    @(posedge clock);
    #1;
    `CHK(readLatency, pick(`TBL_RL_NODBI, 3'd7))
    apb_xfer(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    tv[5] = 8'($random(seed));
    for (int j = 0; j < 6; j++) begin
      apb_xfer(1'b1, `REG_TERMINATION, {24'h0, tv[j]});
      apb_xfer(1'b0, `REG_TERMINATION, 32'h0);
      `CHK(rd, {24'h0, tv[j]})
      #1;
      `CHK(termActive, tv[j][3])
      `CHK(termValue, tv[j][3] ? tv[j][2:0] : 3'h0)
      `CHK(nonTargetTermEn, tv[j][7] | tv[j][3])
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      b = i[2:0];
      dbi = i[3];
      setB = r[0];
      bl = r[1];
      apb_xfer(1'b1, `REG_BAND_CONFIG, {27'h0, bl, 1'b0, b});
      apb_xfer(1'b1, `REG_IO_CONFIG, {25'h0, dbi, 6'h00});
      apb_xfer(1'b1, `REG_LATENCY_MODE, {25'h0, setB, 6'h00});
      apb_xfer(1'b1, `REG_TERMINATION, 32'h8f);
      repeat (2) @(posedge clock);
      #1;
      `CHK(readLatency, pick(dbi ? `TBL_RL_DBI : `TBL_RL_NODBI, b))
      `CHK(writeLatency, pick(setB ? `TBL_WL_B : `TBL_WL_A, b))
      ex = {2'h0, pick(`TBL_READ_TO_PRECHARGE_COUNT, b) + (bl ? 6'd8 : 6'd0), 2'h0, pick(`TBL_NWR, b),
            2'h0, pick(setB ? `TBL_WL_B : `TBL_WL_A, b),
            2'h0, pick(dbi ? `TBL_RL_DBI : `TBL_RL_NODBI, b)};
      apb_xfer(1'b0, `REG_LAT_STATUS, 32'h0);
      `CHK(rd, ex)
      apb_xfer(1'b0, `REG_STATE, 32'h0);
      `CHK(rd, 32'h0000_001f)
      measure(0, r[4:2], pick(`TBL_NWR, b), pick(`TBL_NWR, b) + 1);
      measure(1, r[7:5], pick(`TBL_READ_TO_PRECHARGE_COUNT, b) + (bl ? 8 : 0),
        pick(`TBL_READ_TO_PRECHARGE_COUNT, b) + (bl ? 9 : 1));
      measure(2, 0, pick(setB ? `TBL_WON_B : `TBL_WON_A, b),
        pick(setB ? `TBL_WOFF_B : `TBL_WOFF_A, b) + (bl ? 8 : 0));
      measure(3, 0, pick(dbi ? `TBL_RON_DBI : `TBL_RON_NODBI, b),
        pick(dbi ? `TBL_ROFF_DBI : `TBL_ROFF_NODBI, b) + (bl ? 8 : 0));
    end
    end_of_test();
  end
endmodule : tb_dram_latency_timing
